// ==== rar_pkg.sv ====
// constants and field layout for the right adc line input routing registers
`default_nettype none
package rar_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [6:0] RAR_ADDR_SECOND_RIGHT_LINE = 7'h17;
    localparam logic [6:0] RAR_ADDR_FIRST_LEFT_LINE   = 7'h18;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int RAR_DIFF_BIT  = 7;
    localparam int RAR_LVL_HI    = 6;
    localparam int RAR_LVL_LO    = 3;
    localparam int RAR_BIAS_BIT  = 2;

    // ------------------------------------------------------------
    // reset values and codes
    // ------------------------------------------------------------
    localparam logic       RAR_DIFF_RST    = 1'h0;
    localparam logic [3:0] RAR_LVL_RST     = 4'hf;
    localparam logic       RAR_BIAS_RST    = 1'h0;
    localparam logic [3:0] RAR_LVL_MAX     = 4'h8;
    localparam logic [3:0] RAR_LVL_OFF     = 4'hf;
    localparam logic [4:0] RAR_HALF_DB_STEP = 5'h03;
    localparam logic [7:0] RAR_RD_UNMAPPED = 8'h00;
endpackage : rar_pkg
`default_nettype wire

// ==== rar_lvl_if.sv ====
// level code to decoded routing carrier between the register bank and its decoders
`default_nettype none
interface rar_lvl_if;
    logic [3:0] code;
    logic       connect;
    logic [4:0] atten_half_db;
    logic       reserved;

    modport dec (input code, output connect, output atten_half_db, output reserved);
    modport ctl (output code, input connect, input atten_half_db, input reserved);
endinterface : rar_lvl_if
`default_nettype wire

// ==== rar_lvl_dec.sv ====
// decoder of one 4-bit input level code into connect and attenuation
`default_nettype none
module rar_lvl_dec
    import rar_pkg::*;
(
    rar_lvl_if.dec lvl
);
    wire logic is_gain;
    wire logic is_off;

    assign is_gain = (lvl.code <= RAR_LVL_MAX);
    assign is_off  = (lvl.code == RAR_LVL_OFF);

    // any gain code connects the input, no separate enable
    assign lvl.connect = is_gain;
    // uniform 1.5 db ladder, counted in half db
    assign lvl.atten_half_db = is_gain ? 5'({1'h0, lvl.code} * RAR_HALF_DB_STEP) : 5'h00;
    // reserved codes leave the input unrouted but are flagged; off code is silent
    assign lvl.reserved = !is_gain && !is_off;
endmodule // rar_lvl_dec
`default_nettype wire

// ==== rar_regs.sv ====
// right adc line input routing registers with decoded mixer controls
// ------------------------------------------------------------
// What this block does
// - bit 7 sets second right line differential
// - bit 7 sets first left line differential
// - second right line level code, reset 1111
// - first left line level code, reset 1111
// - gain code auto-connects input to mix
// - code 1111 leaves input disconnected
// - bit 2 enables weak common-mode bias
// - low reserved bits read-only zero
// ------------------------------------------------------------
`default_nettype none
module rar_regs
    import rar_pkg::*;
(
    input  wire logic       mclk_in,
    input  wire logic       srst_in,
    input  wire logic       wr_en_in,
    input  wire logic       rd_en_in,
    input  wire logic [6:0] addr_in,
    input  wire logic [7:0] wdata_in,
    output logic      [7:0] rdata_out,
    output logic            rdata_valid_out,
    output logic            r2_diff_out,
    output logic            r2_connect_out,
    output logic      [4:0] r2_atten_half_db_out,
    output logic            r2_reserved_code_out,
    output logic            l1_diff_out,
    output logic            l1_connect_out,
    output logic      [4:0] l1_atten_half_db_out,
    output logic            l1_reserved_code_out,
    output logic            cm_bias_en_out
);
    import rar_pkg::*;

    // ------------------------------------------------------------
    // stored fields
    // ------------------------------------------------------------
    logic       r2_diff_r;
    logic [3:0] r2_lvl_r;
    logic       bias_r;
    logic       l1_diff_r;
    logic [3:0] l1_lvl_r;
    logic [7:0] rdata_r;
    logic       rvalid_r;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    wire logic       sel_r2;
    wire logic       sel_l1;
    wire logic       wr_r2;
    wire logic       wr_l1;

    assign sel_r2 = (addr_in == RAR_ADDR_SECOND_RIGHT_LINE);
    assign sel_l1 = (addr_in == RAR_ADDR_FIRST_LEFT_LINE);
    // writes to any other address change nothing
    assign wr_r2  = wr_en_in && sel_r2;
    assign wr_l1  = wr_en_in && sel_l1;

    // ------------------------------------------------------------
    // write data fields
    // ------------------------------------------------------------
    wire logic       wd_diff;
    wire logic [3:0] wd_lvl;
    wire logic       wd_bias;

    // only stored fields are picked; reserved low bits of the word drop
    assign wd_diff = wdata_in[RAR_DIFF_BIT];
    assign wd_lvl  = wdata_in[RAR_LVL_HI:RAR_LVL_LO];
    assign wd_bias = wdata_in[RAR_BIAS_BIT];

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    wire logic       r2_diff_nxt;
    wire logic [3:0] r2_lvl_nxt;
    wire logic       bias_nxt;
    wire logic       l1_diff_nxt;
    wire logic [3:0] l1_lvl_nxt;

    // each field holds unless its own register is addressed
    assign r2_diff_nxt = wr_r2 ? wd_diff : r2_diff_r;
    assign r2_lvl_nxt  = wr_r2 ? wd_lvl  : r2_lvl_r;
    assign bias_nxt    = wr_r2 ? wd_bias : bias_r;
    assign l1_diff_nxt = wr_l1 ? wd_diff : l1_diff_r;
    assign l1_lvl_nxt  = wr_l1 ? wd_lvl  : l1_lvl_r;

    // ------------------------------------------------------------
    // read mux
    // ------------------------------------------------------------
    wire logic [7:0] img_r2;
    wire logic [7:0] img_l1;
    wire logic [7:0] rd_mux;
    wire logic [7:0] rdata_nxt;

    // low reserved bits are not stored, so they always read zero
    assign img_r2    = {r2_diff_r, r2_lvl_r, bias_r, 2'h0};
    assign img_l1    = {l1_diff_r, l1_lvl_r, 3'h0};
    assign rd_mux    = sel_r2 ? img_r2 : (sel_l1 ? img_l1 : RAR_RD_UNMAPPED);
    // a read in the cycle of a write still returns the old value
    assign rdata_nxt = rd_en_in ? rd_mux : rdata_r;

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // reserved codes are stored as written; the host must avoid them
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            r2_diff_r <= RAR_DIFF_RST;
            r2_lvl_r  <= RAR_LVL_RST;
            bias_r    <= RAR_BIAS_RST;
        end else begin
            r2_diff_r <= r2_diff_nxt;
            r2_lvl_r  <= r2_lvl_nxt;
            bias_r    <= bias_nxt;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            l1_diff_r <= RAR_DIFF_RST;
            l1_lvl_r  <= RAR_LVL_RST;
        end else begin
            l1_diff_r <= l1_diff_nxt;
            l1_lvl_r  <= l1_lvl_nxt;
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    // registered: answers one cycle after the strobe, holds until the next read
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            rdata_r <= 8'h00;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    // valid is a one-cycle pulse per strobe
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            rvalid_r <= 1'h0;
        end else begin
            rvalid_r <= rd_en_in;
        end
    end

    // ------------------------------------------------------------
    // level decode
    // ------------------------------------------------------------
    rar_lvl_if r2_lvl ();
    rar_lvl_if l1_lvl ();

    assign r2_lvl.code = r2_lvl_r;
    assign l1_lvl.code = l1_lvl_r;

    // one decoder per input keeps both ladders identical
    rar_lvl_dec u_r2_dec (
        .lvl (r2_lvl)
    );
    rar_lvl_dec u_l1_dec (
        .lvl (l1_lvl)
    );

    // ------------------------------------------------------------
    // registered mixer controls
    // ------------------------------------------------------------
    // one flop stage keeps the analog controls glitch free across code changes
    logic       r2_con_r;
    logic [4:0] r2_att_r;
    logic       r2_rsv_r;
    logic       l1_con_r;
    logic [4:0] l1_att_r;
    logic       l1_rsv_r;

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            r2_con_r <= 1'h0;
            r2_att_r <= 5'h00;
            r2_rsv_r <= 1'h0;
        end else begin
            r2_con_r <= r2_lvl.connect;
            r2_att_r <= r2_lvl.atten_half_db;
            r2_rsv_r <= r2_lvl.reserved;
        end
    end

    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            l1_con_r <= 1'h0;
            l1_att_r <= 5'h00;
            l1_rsv_r <= 1'h0;
        end else begin
            l1_con_r <= l1_lvl.connect;
            l1_att_r <= l1_lvl.atten_half_db;
            l1_rsv_r <= l1_lvl.reserved;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // diff and bias leave straight from their flops; only levels pass the decode stage
    assign rdata_out            = rdata_r;
    assign rdata_valid_out      = rvalid_r;
    assign r2_diff_out          = r2_diff_r;
    assign r2_connect_out       = r2_con_r;
    assign r2_atten_half_db_out = r2_att_r;
    assign r2_reserved_code_out = r2_rsv_r;
    assign l1_diff_out          = l1_diff_r;
    assign l1_connect_out       = l1_con_r;
    assign l1_atten_half_db_out = l1_att_r;
    assign l1_reserved_code_out = l1_rsv_r;
    assign cm_bias_en_out       = bias_r;
endmodule // rar_regs
`default_nettype wire

// ==== rar_regs_checker.sv ====
// assertion checker for the right adc line input routing registers
`default_nettype none
module rar_regs_checker
    import rar_pkg::*;
(
    input wire logic       mclk_in, srst_in, wr_en_in, rd_en_in,
    input wire logic [6:0] addr_in,
    input wire logic [7:0] wdata_in, rdata_out,
    input wire logic       rdata_valid_out, r2_diff_out, r2_connect_out, r2_reserved_code_out,
    input wire logic [4:0] r2_atten_half_db_out, l1_atten_half_db_out,
    input wire logic       l1_diff_out, l1_connect_out, l1_reserved_code_out, cm_bias_en_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    wire       w17 = wr_en_in && addr_in == RAR_ADDR_SECOND_RIGHT_LINE;
    wire       w18 = wr_en_in && addr_in == RAR_ADDR_FIRST_LEFT_LINE;
    wire [3:0] lv  = wdata_in[6:3];
    // ----
    // decoded outputs lag the stored code by one cycle
    // ----
    a_r2_diff_store: assert property (w17 |=> r2_diff_out == $past(wdata_in[7]))
        else $error("r2 diff");
    a_l1_diff_store: assert property (w18 |=> l1_diff_out == $past(wdata_in[7]))
        else $error("l1 diff");
    a_bias_store: assert property (w17 |=> cm_bias_en_out == $past(wdata_in[2]))
        else $error("bias");
    a_r2_gain_ladder: assert property (w17 && lv <= RAR_LVL_MAX |-> ##2 r2_connect_out
        && r2_atten_half_db_out == 5'($past(lv, 2)) * RAR_HALF_DB_STEP) else $error("r2 gain");
    a_l1_gain_ladder: assert property (w18 && lv <= RAR_LVL_MAX |-> ##2 l1_connect_out
        && l1_atten_half_db_out == 5'($past(lv, 2)) * RAR_HALF_DB_STEP) else $error("l1 gain");
    a_l1_off_code: assert property (w18 && lv == RAR_LVL_OFF |-> ##2 !l1_connect_out
        && l1_atten_half_db_out == 5'h00) else $error("l1 off");
    a_r2_rsvd_code: assert property (w17 && lv > RAR_LVL_MAX && lv < RAR_LVL_OFF |-> ##2
        r2_reserved_code_out && !r2_connect_out) else $error("r2 code");
    a_r2_read_zeros: assert property (rd_en_in && addr_in == RAR_ADDR_SECOND_RIGHT_LINE
        |=> rdata_valid_out && rdata_out[1:0] == 2'h0) else $error("r2 read");
    a_l1_read_zeros: assert property (rd_en_in && addr_in == RAR_ADDR_FIRST_LEFT_LINE
        |=> rdata_valid_out && rdata_out[2:0] == 3'h0) else $error("l1 read");
    c_r2_route: cover property (w17 ##2 r2_connect_out);
    c_l1_rsvd: cover property (l1_reserved_code_out);
    c_read: cover property (rdata_valid_out);
endmodule // rar_regs_checker
bind rar_regs rar_regs_checker u_chk (.mclk_in(mclk_in), .srst_in(srst_in), .wr_en_in(wr_en_in),
    .rd_en_in(rd_en_in), .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
    .rdata_valid_out(rdata_valid_out), .r2_diff_out(r2_diff_out), .r2_connect_out(r2_connect_out),
    .r2_reserved_code_out(r2_reserved_code_out), .r2_atten_half_db_out(r2_atten_half_db_out),
    .l1_atten_half_db_out(l1_atten_half_db_out), .l1_diff_out(l1_diff_out),
    .l1_connect_out(l1_connect_out), .l1_reserved_code_out(l1_reserved_code_out),
    .cm_bias_en_out(cm_bias_en_out));
`default_nettype wire

// ==== rar_regs_tb_top.sv ====
// self-checking bench for the right adc line input routing registers
`default_nettype none
module rar_regs_tb_top;
    import rar_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk_in = 1'h0, srst_in = 1'h1, wr_en_in = 1'h0, rd_en_in = 1'h0;
    logic [6:0] addr_in = 7'h00;
    logic [7:0] wdata_in = 8'h00, rdata_out;
    logic       rdata_valid_out, r2_diff_out, r2_connect_out, r2_reserved_code_out;
    logic       l1_diff_out, l1_connect_out, l1_reserved_code_out, cm_bias_en_out;
    logic [4:0] r2_atten_half_db_out, l1_atten_half_db_out;
    int         mismatches = 0, n_tests = 0;
    always #12.5 mclk_in = ~mclk_in;
    rar_regs DUT (.mclk_in(mclk_in), .srst_in(srst_in), .wr_en_in(wr_en_in),
        .rd_en_in(rd_en_in), .addr_in(addr_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
        .rdata_valid_out(rdata_valid_out), .r2_diff_out(r2_diff_out), .r2_connect_out(r2_connect_out),
        .r2_atten_half_db_out(r2_atten_half_db_out), .r2_reserved_code_out(r2_reserved_code_out),
        .l1_diff_out(l1_diff_out), .l1_connect_out(l1_connect_out), .cm_bias_en_out(cm_bias_en_out),
        .l1_atten_half_db_out(l1_atten_half_db_out), .l1_reserved_code_out(l1_reserved_code_out));
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // waits until the decoded outputs of this write have landed
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge mclk_in);
        wr_en_in <= 1'h1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge mclk_in);
        wr_en_in <= 1'h0;
        @(posedge mclk_in);
        #1;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge mclk_in);
        rd_en_in <= 1'h1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_en_in <= 1'h0;
        #1;
        chk("valid", 8'h01, 8'(rdata_valid_out));
        chk("rdata", exp, rdata_out);
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    // ----
    // sequence
    // ----
    initial begin
        repeat (4) @(posedge mclk_in);
        srst_in <= 1'h0;
        rd(RAR_ADDR_SECOND_RIGHT_LINE, 8'h78);
        rd(RAR_ADDR_FIRST_LEFT_LINE, 8'h78);
        chk("conn", 8'h00, {6'h00, r2_connect_out, l1_connect_out});
        // reserved bits 1:0 written as ones; bias stays at one through the second pass
        // first pass drives second right line routing, second pass drives first left line routing
        for (int i = 0; i < 32; i++) begin
            logic [3:0] c;
            c = i[3:0];
            wr(i[4] ? RAR_ADDR_FIRST_LEFT_LINE : RAR_ADDR_SECOND_RIGHT_LINE,
                {c[1], c, c[0], 2'h3});
            chk("diff", 8'(c[1]), 8'(i[4] ? l1_diff_out : r2_diff_out));
            chk("conn", 8'(c <= 4'h8), 8'(i[4] ? l1_connect_out : r2_connect_out));
            chk("atten", (c <= 4'h8) ? 8'(c) * 8'h03 : 8'h00,
                8'(i[4] ? l1_atten_half_db_out : r2_atten_half_db_out));
            chk("rsvd", 8'(c > 4'h8 && c < 4'hf),
                8'(i[4] ? l1_reserved_code_out : r2_reserved_code_out));
            chk("bias", 8'(i[4] | c[0]), 8'(cm_bias_en_out));
            rd(i[4] ? RAR_ADDR_FIRST_LEFT_LINE : RAR_ADDR_SECOND_RIGHT_LINE,
                {c[1], c, i[4] ? 3'h0 : {c[0], 2'h0}});
        end
        wr(7'h19, 8'h00);
        rd(7'h19, RAR_RD_UNMAPPED);
        chk("l1 diff", 8'h01, 8'(l1_diff_out));
        @(posedge mclk_in);
        srst_in <= 1'h1;
        @(posedge mclk_in);
        srst_in <= 1'h0;
        rd(RAR_ADDR_SECOND_RIGHT_LINE, 8'h78);
        rd(RAR_ADDR_FIRST_LEFT_LINE, 8'h78);
        chk("l1 diff", 8'h00, 8'(l1_diff_out));
        chk("bias", 8'h00, 8'(cm_bias_en_out));
        give_verdict();
    end
    initial begin
        repeat (3000) @(posedge mclk_in);
        mismatches++;
        give_verdict();
    end
endmodule // rar_regs_tb_top
`default_nettype wire
